//--- verilog/vepi_pkg.sv
// Shared constants for the 8-bit pixel input port and its video source.
package vepi_pkg;

    // ------------------------------------------------------------------
    // Control byte layout and input mode codes
    // ------------------------------------------------------------------
    localparam int         MODE_LSB       = 4;
    localparam int         MODE_MSB       = 6;
    localparam int         EDGE_LSB       = 1;
    localparam int         EDGE_MSB       = 2;
    localparam logic [7:0] CTRL_RESET     = 8'h00;
    localparam logic [2:0] MODE_SD        = 3'h0;
    localparam logic [2:0] MODE_DDR       = 3'h2;
    localparam logic [2:0] MODE_ED54      = 3'h7;

    // ------------------------------------------------------------------
    // Timing reference codes and blanking levels
    // ------------------------------------------------------------------
    localparam logic [7:0] CODE_ONES      = 8'hFF;
    localparam logic [7:0] CODE_ZEROS     = 8'h00;
    localparam logic [7:0] BLANK_LUMA     = 8'h10;
    localparam logic [7:0] BLANK_CHROMA   = 8'h80;
    localparam int         XY_H           = 4;
    localparam int         XY_V           = 5;
    localparam int         XY_F           = 6;
    localparam int         CODE_WORDS     = 4;

    // ------------------------------------------------------------------
    // Clock timing
    // ------------------------------------------------------------------
    localparam int         SYS_CLK_MHZ    = 100;
    localparam int         SD_PCLK_MHZ    = 27;
    localparam int         ED54_PCLK_MHZ  = 54;
    // A half period of the pixel clock, rounded down, never below one.
    localparam int         SD_HALF_RAW    = SYS_CLK_MHZ / (2 * SD_PCLK_MHZ);
    localparam int         ED54_HALF_RAW  = SYS_CLK_MHZ / (2 * ED54_PCLK_MHZ);
    localparam logic [1:0] SD_HALF_CYC    = (SD_HALF_RAW < 1) ? 2'h1
                                            : 2'(SD_HALF_RAW);
    localparam logic [1:0] ED54_HALF_CYC  = (ED54_HALF_RAW < 1) ? 2'h1
                                            : 2'(ED54_HALF_RAW);
    // Double rate needs a mid-period slot to move data away from edges.
    localparam logic [1:0] DDR_HALF_CYC   = 2'h2;

    // ------------------------------------------------------------------
    // Line and frame shape produced by the source
    // ------------------------------------------------------------------
    localparam logic [4:0] ACTIVE_WORDS   = 5'h10;
    localparam logic [4:0] BLANK_WORDS    = 5'h04;
    localparam logic [2:0] LINES_FRAME    = 3'h6;
    localparam logic [2:0] VBLANK_LINES   = 3'h2;

    // ------------------------------------------------------------------
    // Sample buffer
    // ------------------------------------------------------------------
    localparam int         FIFO_DEPTH     = 32;
    localparam int         FIFO_WIDTH     = 10;

endpackage

//--- verilog/vepi_if.sv
// Pixel link between the video source and the encoder input port.
interface vepi_if;

    // Pixel clock, data bus and optional external syncs.
    logic       pixel_clock_input;
    logic [7:0] pixel_bus;
    logic       line_sync_n;
    logic       frame_sync_n;

    modport source (
        output pixel_clock_input,
        output pixel_bus,
        output line_sync_n,
        output frame_sync_n
    );

    modport encoder (
        input  pixel_clock_input,
        input  pixel_bus,
        input  line_sync_n,
        input  frame_sync_n
    );

endinterface

//--- verilog/vepi_fifo.sv
// Sample FIFO with a registered output stage.
module vepi_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             arst_n,
    // Filling side
    input  wire logic             in_valid,
    output      logic             in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Draining side
    output      logic             out_valid,
    input  wire logic             out_ready,
    output      logic [WIDTH-1:0] out_data
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    wire              in_fire;
    wire              load;

    // -----------------------------------------------------------------
    // Flow control
    // -----------------------------------------------------------------
    // The output register counts as one extra slot beyond DEPTH.
    assign in_ready = (count != (AW+1)'(DEPTH));
    assign in_fire  = in_valid & in_ready;
    assign load     = (count != '0) & (~out_valid | out_ready);

    // Storage array carries no reset.
    always_ff @(posedge sys_clk) begin
        if (in_fire) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Pointers, fill level and output stage.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr    <= '0;
            rd_ptr    <= '0;
            count     <= '0;
            out_valid <= 1'b0;
            out_data  <= '0;
        end else begin
            wr_ptr <= in_fire ? wr_ptr + 1'b1 : wr_ptr;
            rd_ptr <= load ? rd_ptr + 1'b1 : rd_ptr;
            count  <= count + (AW+1)'(in_fire) - (AW+1)'(load);
            if (load) begin
                out_valid <= 1'b1;
                out_data  <= mem[rd_ptr];
            end else if (out_ready) begin
                out_valid <= 1'b0;
            end
        end
    end

endmodule

//--- verilog/vepi_encoder.sv
// Encoder end of the 8-bit pixel input port.
//
// What this block does
// - Input mode from control bits 6 to 4.
// - Standard definition mode after reset.
// - Code 000: 8-bit 4:2:2 at 27 MHz.
// - Timing from external syncs or embedded codes.
// - Bus bit 0 is the least significant.
// - Standard definition framing follows BT.601/656 conventions.
// - Code 010: capture on both clock edges.
// - Double rate: luma one edge, chroma other.
// - Luma edge chosen by control bit 1; bit 2 is ignored.
// - Code 111: 8-bit 4:2:2 at 54 MHz.
// - 54 MHz mode uses embedded codes only.
module vepi_encoder (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       arst_n,
    // Pixel link from the source
    vepi_if.encoder         vid,
    // Control byte write
    input  wire logic       ctrl_wr,
    input  wire logic [7:0] ctrl_data,
    input  wire logic       ext_sync_en,
    // Received sample stream
    output      logic       pix_valid,
    input  wire logic       pix_ready,
    output      logic [7:0] pix_data,
    output      logic       pix_is_luma,
    output      logic       pix_line_start,
    // Status
    output      logic [2:0] active_mode,
    output      logic       overflow
);

    // -----------------------------------------------------------------
    // Declarations
    // -----------------------------------------------------------------
    logic [7:0] ctrl;
    logic       pclk_q;
    logic       pclk_prev;
    logic [7:0] bus_q;
    logic       lsync_q;
    logic       fsync_q;
    logic       ext_active_prev;
    logic [7:0] hist1;
    logic [7:0] hist2;
    logic [7:0] hist3;
    logic       emb_active;
    logic       line_pend;
    logic [1:0] phase;
    wire  [2:0] mode;
    wire  [1:0] edge_sel;
    wire        mode_ok;
    wire        is_ddr;
    wire        luma_fall;
    wire        rise;
    wire        fall;
    wire        capture;
    wire        use_ext;
    wire        code_hit;
    wire        is_eav;
    wire        is_sav;
    wire        word_ones;
    wire        ext_active;
    wire        ext_start;
    wire        active_now;
    wire        push;
    wire        sample_luma;
    wire        fifo_ready;
    localparam int FIFO_W = vepi_pkg::FIFO_WIDTH;
    wire        resync;
    wire [FIFO_W-1:0] fifo_in;

    // -----------------------------------------------------------------
    // Control decode
    // -----------------------------------------------------------------
    // Only the three 8-bit input modes are accepted; other codes stop
    // capture rather than guess at a wider-bus format.
    assign mode      = ctrl[vepi_pkg::MODE_MSB:vepi_pkg::MODE_LSB];
    assign edge_sel  = ctrl[vepi_pkg::EDGE_MSB:vepi_pkg::EDGE_LSB];
    assign is_ddr    = (mode == vepi_pkg::MODE_DDR);
    assign mode_ok   = (mode == vepi_pkg::MODE_SD)
                     | is_ddr
                     | (mode == vepi_pkg::MODE_ED54);
    assign luma_fall = edge_sel[0];
    // External syncs are never trusted in the 54 MHz mode.
    assign use_ext   = ext_sync_en
                     & (mode != vepi_pkg::MODE_ED54);
    // A mode change invalidates any partly seen timing code.
    assign resync    = ctrl_wr
                     & (ctrl_data[vepi_pkg::MODE_MSB:vepi_pkg::MODE_LSB]
                        != mode);

    // Control byte; reset value selects standard definition.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl <= vepi_pkg::CTRL_RESET;
        end else if (ctrl_wr) begin
            ctrl <= ctrl_data;
        end
    end

    // -----------------------------------------------------------------
    // Pin sampling and edge detection
    // -----------------------------------------------------------------
    // Pins are synchronous, so one register stage aligns clock and data.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pclk_q          <= 1'b0;
            pclk_prev       <= 1'b0;
            bus_q           <= '0;
            lsync_q         <= 1'b1;
            fsync_q         <= 1'b1;
            ext_active_prev <= 1'b0;
        end else begin
            pclk_q          <= vid.pixel_clock_input;
            pclk_prev       <= pclk_q;
            bus_q           <= vid.pixel_bus;
            lsync_q         <= vid.line_sync_n;
            fsync_q         <= vid.frame_sync_n;
            ext_active_prev <= ext_active;
        end
    end

    assign rise    = pclk_q & ~pclk_prev;
    assign fall    = ~pclk_q & pclk_prev;
    // Double rate takes a word on every edge, the other two accepted modes on rising.
    assign capture = mode_ok & (is_ddr ? (rise | fall) : rise);

    // -----------------------------------------------------------------
    // Embedded timing code detection
    // -----------------------------------------------------------------
    assign word_ones = (bus_q == vepi_pkg::CODE_ONES);
    assign code_hit  = capture
                     & (hist3 == vepi_pkg::CODE_ONES)
                     & (hist2 == vepi_pkg::CODE_ZEROS)
                     & (hist1 == vepi_pkg::CODE_ZEROS);
    assign is_eav    = code_hit & bus_q[vepi_pkg::XY_H];
    assign is_sav    = code_hit & ~bus_q[vepi_pkg::XY_H]
                     & ~bus_q[vepi_pkg::XY_V];

    // History of the last three captured words.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            hist1 <= '0;
            hist2 <= '0;
            hist3 <= '0;
        end else if (resync) begin
            hist1 <= '0;
            hist2 <= '0;
            hist3 <= '0;
        end else if (capture) begin
            hist1 <= bus_q;
            hist2 <= hist1;
            hist3 <= hist2;
        end
    end

    // Active video window from the codes. An all-ones word cannot be
    // video, so it closes the window before the end code completes and
    // keeps the preamble out of the sample stream.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            emb_active <= 1'b0;
        end else if (resync) begin
            emb_active <= 1'b0;
        end else if (is_sav) begin
            emb_active <= 1'b1;
        end else if (is_eav | (capture & word_ones)) begin
            emb_active <= 1'b0;
        end
    end

    // -----------------------------------------------------------------
    // Timing source selection
    // -----------------------------------------------------------------
    // Both syncs high marks active video in external mode.
    assign ext_active = lsync_q & fsync_q;
    assign ext_start  = ext_active & ~ext_active_prev;
    assign active_now = use_ext ? ext_active : emb_active;

    // -----------------------------------------------------------------
    // Sample tagging and hand-off
    // -----------------------------------------------------------------
    assign push = capture & active_now & ~(~use_ext & word_ones);
    // Double rate tags luma by edge; single rate by position in the
    // Cb Y Cr Y sequence, where every odd word is luma.
    assign sample_luma = is_ddr ? (luma_fall ? fall : rise)
                                : phase[0];
    assign fifo_in = {line_pend, sample_luma, bus_q};

    // Line start marker and sample phase.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            line_pend <= 1'b0;
            phase     <= '0;
        end else if (use_ext ? ext_start : is_sav) begin
            line_pend <= 1'b1;
            phase     <= '0;
        end else if (push) begin
            line_pend <= 1'b0;
            phase     <= phase + 2'h1;
        end
    end

    // The link cannot be stalled, so a full buffer drops the sample and
    // reports it; the sink must keep up on average.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            overflow    <= 1'b0;
            active_mode <= vepi_pkg::MODE_SD;
        end else begin
            overflow    <= push & ~fifo_ready;
            active_mode <= mode;
        end
    end

    // Sample buffer between the link and the user side.
    vepi_fifo #(
        .WIDTH (FIFO_W),
        .DEPTH (vepi_pkg::FIFO_DEPTH)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .arst_n    (arst_n),
        .in_valid  (push),
        .in_ready  (fifo_ready),
        .in_data   (fifo_in),
        .out_valid (pix_valid),
        .out_ready (pix_ready),
        .out_data  ({pix_line_start, pix_is_luma, pix_data})
    );

endmodule

//--- verilog/vepi_source.sv
// Video source end of the 8-bit pixel input port.
module vepi_source (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       arst_n,
    // Pixel link to the encoder
    vepi_if.source          vid,
    // Configuration, matching the encoder control byte
    input  wire logic [2:0] mode,
    input  wire logic       luma_fall,
    input  wire logic       ext_sync_en,
    // Active samples in Cb Y Cr Y order
    input  wire logic       sample_valid,
    output      logic       sample_ready,
    input  wire logic [7:0] sample_data,
    // Status
    output      logic       underflow
);

    typedef enum logic [3:0] {
        VEPI_EAV    = 4'b0001,
        VEPI_BLANK  = 4'b0010,
        VEPI_SAV    = 4'b0100,
        VEPI_ACTIVE = 4'b1000
    } vepi_state_e;

    vepi_state_e state;
    vepi_state_e next_state;
    logic [1:0]  cnt;
    logic [4:0]  widx;
    logic [2:0]  line;
    logic        wpar;
    logic        hold_full;
    logic [7:0]  hold;
    logic        pclk;
    logic [7:0]  next_word;
    logic [4:0]  next_widx;
    wire  [1:0]  half;
    wire         is_ddr;
    wire         toggle;
    wire         upd;
    wire         stall;
    wire         adv;
    wire         vblank;
    wire         use_ext;
    wire         take;
    wire  [7:0]  xy;
    wire  [7:0]  fill;

    // Timing reference word with protection bits; progressive, F=0.
    function automatic logic [7:0] xy_word(input logic f, input logic v,
                                           input logic h);
        xy_word = {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h};
    endfunction

    // -----------------------------------------------------------------
    // Pixel clock and update slot
    // -----------------------------------------------------------------
    assign is_ddr = (mode == vepi_pkg::MODE_DDR);
    assign half   = is_ddr ? vepi_pkg::DDR_HALF_CYC
                  : (mode == vepi_pkg::MODE_ED54) ? vepi_pkg::ED54_HALF_CYC
                  : vepi_pkg::SD_HALF_CYC;
    assign toggle = (cnt >= half - 2'h1);
    // Single rate moves data on the falling edge so it is settled at
    // the rising edge; double rate moves it mid-way between edges.
    assign upd    = is_ddr ? (cnt == 2'h0) : (toggle & pclk);
    // Even words are chroma; wait a word slot until the next edge is
    // the chroma edge, so luma lands on the chosen edge.
    assign stall  = is_ddr & (((~pclk) ^ luma_fall) != wpar);
    assign adv    = upd & ~stall;

    // -----------------------------------------------------------------
    // Word generation
    // -----------------------------------------------------------------
    assign vblank  = (line < vepi_pkg::VBLANK_LINES);
    assign use_ext = ext_sync_en & (mode != vepi_pkg::MODE_ED54);
    assign xy      = xy_word(1'b0, vblank, state == VEPI_EAV);
    assign fill    = widx[0] ? vepi_pkg::BLANK_LUMA
                             : vepi_pkg::BLANK_CHROMA;
    assign take    = adv & (state == VEPI_ACTIVE) & ~vblank;

    // Next word and sequence position.
    always_comb begin
        next_state = state;
        next_widx  = widx + 5'h1;
        next_word  = fill;
        unique case (state)
            VEPI_EAV, VEPI_SAV: begin
                next_word = (widx == 5'h0) ? vepi_pkg::CODE_ONES
                          : (widx == 5'h3) ? xy
                          : vepi_pkg::CODE_ZEROS;
                if (widx == 5'(vepi_pkg::CODE_WORDS - 1)) begin
                    next_widx  = '0;
                    next_state = (state == VEPI_EAV) ? VEPI_BLANK
                                                     : VEPI_ACTIVE;
                end
            end
            VEPI_BLANK: begin
                if (widx == vepi_pkg::BLANK_WORDS - 5'h1) begin
                    next_widx  = '0;
                    next_state = VEPI_SAV;
                end
            end
            VEPI_ACTIVE: begin
                if (!vblank && hold_full) begin
                    next_word = hold;
                end
                if (widx == vepi_pkg::ACTIVE_WORDS - 5'h1) begin
                    next_widx  = '0;
                    next_state = VEPI_EAV;
                end
            end
        endcase
    end

    // Clock divider and word sequencer.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt   <= '0;
            pclk  <= 1'b0;
            state <= VEPI_BLANK;
            widx  <= '0;
            line  <= '0;
            wpar  <= 1'b0;
            vid.pixel_bus    <= vepi_pkg::BLANK_CHROMA;
            vid.line_sync_n  <= 1'b1;
            vid.frame_sync_n <= 1'b1;
        end else begin
            cnt  <= toggle ? 2'h0 : cnt + 2'h1;
            pclk <= toggle ? ~pclk : pclk;
            if (adv) begin
                state <= next_state;
                widx  <= next_widx;
                wpar  <= ~wpar;
                vid.pixel_bus   <= next_word;
                vid.line_sync_n <= (state == VEPI_ACTIVE);
                if (state != VEPI_ACTIVE) begin
                    vid.frame_sync_n <= ~(use_ext & vblank);
                end
                if (state == VEPI_ACTIVE && next_state == VEPI_EAV) begin
                    line <= (line == vepi_pkg::LINES_FRAME - 3'h1)
                            ? 3'h0 : line + 3'h1;
                end
            end
        end
    end

    assign vid.pixel_clock_input = pclk;

    // -----------------------------------------------------------------
    // User-side holding register
    // -----------------------------------------------------------------
    // A missing sample is replaced by a blanking level and flagged.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            hold         <= '0;
            hold_full    <= 1'b0;
            sample_ready <= 1'b1;
            underflow    <= 1'b0;
        end else begin
            underflow <= take & ~hold_full;
            if (sample_valid && sample_ready) begin
                hold         <= sample_data;
                hold_full    <= 1'b1;
                sample_ready <= 1'b0;
            end else if (take) begin
                hold_full    <= 1'b0;
                sample_ready <= 1'b1;
            end
        end
    end

endmodule

//--- dv/vepi_checker.sv
// Assertions on the pixel link between the source and the encoder.
module vepi_checker (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       arst_n,
    // Pixel link
    input  wire logic       pixel_clock_input,
    input  wire logic [7:0] pixel_bus,
    input  wire logic       line_sync_n,
    input  wire logic       frame_sync_n
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);

    // Last word and the distinct word before it; repeated zeros do not
    // move the bus, so preambles are tracked by changes only.
    logic [7:0] last;
    logic [7:0] prev;
    wire logic  nw = pixel_bus != last;
    wire logic  xy = nw && last == 8'h00 && prev == 8'hFF;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            last <= 8'h80;
            prev <= 8'h80;
        end else begin
            last <= pixel_bus;
            if (nw) prev <= last;
        end
    end

    // Link timing and timing reference words.
    a_bus_held_rise: assert property ($rose(pixel_clock_input) |->
        $stable(pixel_bus)) else $error("bus moved at clock rise");
    a_clk_keeps_running: assert property (
        $stable(pixel_clock_input) [*3] |=> $changed(pixel_clock_input))
        else $error("pixel clock stopped");
    a_bus_move_slot: assert property ($changed(pixel_bus) |->
        $fell(pixel_clock_input)
        || $past(pixel_clock_input) != $past(pixel_clock_input, 2))
        else $error("bus moved outside its slot");
    a_preamble_ones_zero: assert property (nw && last == 8'hFF |->
        pixel_bus == 8'h00) else $error("ones word not followed by zeros");
    a_xy_marker_set: assert property (xy |-> pixel_bus[7])
        else $error("code word lacks its marker bit");
    a_xy_parity_ok: assert property (xy |-> pixel_bus[3:0] ==
        {^pixel_bus[5:4], pixel_bus[6] ^ pixel_bus[4], ^pixel_bus[6:5],
        ^pixel_bus[6:4]}) else $error("code word protection bits wrong");
    a_field_bit_zero: assert property (xy |-> !pixel_bus[6])
        else $error("code word field bit set");
    a_frame_in_hblank: assert property ($changed(frame_sync_n) |->
        !line_sync_n) else $error("frame sync moved in active video");
endmodule

//--- dv/testbench.sv
// Self-checking bench joining the source and the encoder over the link.
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    // -----------------------------------------------------------------
    // Signals and instances
    // -----------------------------------------------------------------
    logic       sys_clk = 1'b0;
    logic       arst_n = 1'b0;
    logic       ctrl_wr = 1'b0;
    logic [7:0] ctrl_data = 8'h00;
    logic [2:0] mode = 3'h0;
    logic       luma_fall = 1'b0;
    logic       ext_sync_en = 1'b0;
    logic       sample_valid = 1'b1;
    logic [7:0] sample_data = 8'h20;
    logic       pix_ready = 1'b1;
    logic       sample_ready, underflow, pix_valid, pix_is_luma;
    logic       pix_line_start, overflow, synced = 1'b0, ovf_seen = 1'b0;
    logic [7:0] pix_data, pos = 8'h00, last = 8'h00;
    logic [2:0] active_mode;
    logic [4:0] tbl [5] = '{5'h00, 5'h01, 5'h08, 5'h0B, 5'h1D};
    int         n_errors = 0, n_tests = 0, lines = 0, cyc = 0;
    vepi_if i_vepi_if ();
    vepi_encoder i_vepi_encoder (.sys_clk, .arst_n, .vid(i_vepi_if),
        .ctrl_wr, .ctrl_data, .ext_sync_en, .pix_valid, .pix_ready,
        .pix_data, .pix_is_luma, .pix_line_start, .active_mode, .overflow);
    vepi_source i_vepi_source (.sys_clk, .arst_n, .vid(i_vepi_if), .mode,
        .luma_fall, .ext_sync_en, .sample_valid, .sample_ready,
        .sample_data, .underflow);
    vepi_checker i_vepi_checker (.sys_clk, .arst_n,
        .pixel_clock_input(i_vepi_if.pixel_clock_input),
        .pixel_bus(i_vepi_if.pixel_bus),
        .line_sync_n(i_vepi_if.line_sync_n),
        .frame_sync_n(i_vepi_if.frame_sync_n));
    initial forever #5 sys_clk = ~sys_clk;

    // Samples run 0x20..0x9F so they never mimic a timing code.
    function automatic logic [7:0] nxt(logic [7:0] d);
        return 8'h20 + ((d - 8'h1F) & 8'h7F);
    endfunction
    task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wait_n(int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // Sample feed, overflow latch and a hang guard.
    always @(posedge sys_clk) begin
        if (sample_valid && sample_ready) sample_data <= nxt(sample_data);
        if (overflow === 1'b1) ovf_seen <= 1'b1;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            wrap_up;
        end
    end
    // Received stream: Cb Y Cr Y order, consecutive data, whole lines.
    always @(posedge sys_clk) if (!ovf_seen && pix_valid && pix_ready) begin
        last <= pix_data;
        if (pix_line_start) begin
            if (synced) check("line_len", pos, 8'h10);
            check("first_luma", {7'h0, pix_is_luma}, 8'h00);
            synced <= 1'b1;
            pos <= 8'h01;
            lines <= lines + 1;
        end else if (synced) begin
            check("luma", {7'h0, pix_is_luma}, {7'h0, pos[0]});
            check("data", pix_data, nxt(last));
            pos <= pos + 8'h01;
        end
    end

    // -----------------------------------------------------------------
    // Scenarios
    // -----------------------------------------------------------------
    task automatic wr_ctrl(logic [7:0] b);
        @(posedge sys_clk);
        synced <= 1'b0;
        ctrl_wr <= 1'b1;
        ctrl_data <= b;
        @(posedge sys_clk);
        ctrl_wr <= 1'b0;
        wait_n(3);
        check("active_mode", {5'h0, active_mode}, {5'h0, b[6:4]});
    endtask
    task automatic run_mode(logic [2:0] m, logic f, logic e);
        int l0;
        mode <= m;
        luma_fall <= f;
        ext_sync_en <= e;
        wr_ctrl({1'b0, m, 2'b00, f, 1'b0});
        wait_n(200);
        l0 = lines;
        wait_n(500);
        check("lines", 8'(lines-l0 >= 4), 8'h01);
        $display("done mode %h fall %b ext %b", m, f, e);
    endtask
    // Stalled sink fills the buffer until a word is dropped.
    task automatic t_overflow;
        int pops;
        logic [7:0] d;
        synced <= 1'b0;
        ovf_seen <= 1'b0;
        pix_ready <= 1'b0;
        wait_n(400);
        d = pix_data;
        check("overflow", {7'h0, ovf_seen}, 8'h01);
        check("held_valid", {7'h0, pix_valid}, 8'h01);
        wait_n(5);
        check("held_data", pix_data, d);
        pops = 0;
        pix_ready <= 1'b1;
        repeat (40) begin
            @(posedge sys_clk);
            if (pix_valid === 1'b1) pops++;
        end
        check("drained", 8'(pops >= vepi_pkg::FIFO_DEPTH), 8'h01);
        wait_n(200);
        ovf_seen <= 1'b0;
        $display("done overflow");
    endtask
    // An unknown mode code is stored but nothing is captured.
    task automatic t_illegal;
        int n;
        n = 0;
        wr_ctrl(8'h10);
        wait_n(20);
        repeat (300) begin
            @(posedge sys_clk);
            if (pix_valid !== 1'b0) n++;
        end
        check("no_capture", 8'(n), 8'h00);
        $display("done illegal mode");
    endtask

    initial begin
        wait_n(19);
        check("rst_bus", i_vepi_if.pixel_bus, 8'h80);
        @(posedge sys_clk);
        arst_n <= 1'b1;
        wait_n(600);
        check("rst_mode", {5'h0, active_mode}, 8'h00);
        check("rst_lines", 8'(lines >= 4), 8'h01);
        $display("done reset default");
        for (int i = 0; i < 5; i++) run_mode(tbl[i][4:2], tbl[i][1], tbl[i][0]);
        t_overflow;
        t_illegal;
        run_mode(3'h0, 1'b0, 1'b0);
        wrap_up;
    end
endmodule
